/* verilog/pmc_pkg.sv */
// Package: register map, field layout and sizes of the output macrocell block
`default_nettype none
package pmc_pkg;
   localparam int NUM_CELLS   = 8;
   localparam int NUM_INPUTS  = 8;
   localparam int TERMS_CELL  = 8;
   localparam int NUM_TERMS   = NUM_CELLS * TERMS_CELL;
   localparam int NUM_SIGS    = NUM_INPUTS + NUM_CELLS;
   localparam int NUM_COLS    = 2 * NUM_SIGS;
   localparam int SIG_BITS    = 64;
   localparam int ADDR_W      = 12;
   localparam int DATA_W      = 32;

   // Register byte offsets
   localparam logic [ADDR_W-1:0] CTRL_OFS     = 12'h000;
   localparam logic [ADDR_W-1:0] RUN_OFS      = 12'h004;
   localparam logic [ADDR_W-1:0] SIG_LO_OFS   = 12'h008;
   localparam logic [ADDR_W-1:0] SIG_HI_OFS   = 12'h00C;
   localparam logic [ADDR_W-1:0] SECURE_OFS   = 12'h010;
   localparam logic [ADDR_W-1:0] ERASE_OFS    = 12'h014;
   localparam logic [ADDR_W-1:0] STATUS_OFS   = 12'h018;
   localparam logic [ADDR_W-1:0] PRELOAD_OFS  = 12'h01C;
   localparam logic [ADDR_W-1:0] ARRAY_OFS    = 12'h100;
   localparam logic [ADDR_W-1:0] ARRAY_MASK   = 12'hF00;

   // Control word field positions
   localparam int CTRL_ALLOW_POS  = 0;
   localparam int CTRL_FAMILY_POS = 1;
   localparam int CTRL_LOCAL_POS  = 8;
   localparam int CTRL_POL_POS    = 16;

   // Status word field positions
   localparam int ST_RUN_POS    = 0;
   localparam int ST_SECURE_POS = 1;
   localparam int ST_UNSUP_POS  = 2;
   localparam int ST_Q_POS      = 8;
   localparam int ST_OE_POS     = 16;
   localparam int ST_OUT_POS    = 24;

   // Values after reset
   localparam logic [NUM_CELLS-1:0] Q_RESET     = 8'h00;
   localparam logic [DATA_W-1:0]    FUSE_RESET  = 32'h0000_0000;
   localparam logic [SIG_BITS-1:0]  SIG_RESET   = 64'h0000_0000_0000_0000;
   localparam logic [DATA_W-1:0]    WORD_ZERO   = 32'h0000_0000;

   typedef enum logic [2:0] {
      PMC_REGISTERED,
      PMC_COMB_IO,
      PMC_COMB_OUT,
      PMC_INPUT,
      PMC_UNSUPPORTED
   } pmc_mode_t;
endpackage
`default_nettype wire

/* verilog/pmc_macrocell_top.sv */
// Output macrocell array with sum-of-products logic and APB configuration
`default_nettype none

module pmc_macrocell_top (
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [pmc_pkg::ADDR_W-1:0]    paddr,
   input  wire logic [pmc_pkg::DATA_W-1:0]    pwdata,
   output var  logic [pmc_pkg::DATA_W-1:0]    prdata,
   output var  logic                          pready,
   output var  logic                          pslverr,
   input  wire logic [pmc_pkg::NUM_INPUTS-1:0] in_pin,
   input  wire logic                          clk_pin,
   input  wire logic                          oe_n_pin,
   input  wire logic [pmc_pkg::NUM_CELLS-1:0] io_in,
   output var  logic [pmc_pkg::NUM_CELLS-1:0] io_out,
   output var  logic [pmc_pkg::NUM_CELLS-1:0] io_oe
);
   localparam int NC = pmc_pkg::NUM_CELLS;
   localparam int NI = pmc_pkg::NUM_INPUTS;
   localparam int NS = NI + NC + 2;

   // Pin synchronisers: three stages, second and third must agree
   logic [NS-1:0]  raw;
   logic [NS-1:0]  s1_ff;
   logic [NS-1:0]  s2_ff;
   logic [NS-1:0]  s3_ff;
   logic [NS-1:0]  pin_ff;
   logic [NC-1:0]  p_io;
   logic [NI-1:0]  p_in;
   logic           p_clk;
   logic           p_oe_n;
   logic           clk_prev_ff;
   logic           clk_rise;

   assign raw = {oe_n_pin, clk_pin, in_pin, io_in};

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
      end else begin
         s1_ff <= raw;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
      end
   end

   genvar b;
   generate
      for (b = 0; b < NS; b++) begin : g_filt
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               pin_ff[b] <= 1'b0;
            end else if (s2_ff[b] == s3_ff[b]) begin
               pin_ff[b] <= s3_ff[b];
            end
         end
      end
   endgenerate

   assign p_io   = pin_ff[NC-1:0];
   assign p_in   = pin_ff[NC+NI-1:NC];
   assign p_clk  = pin_ff[NC+NI];
   assign p_oe_n = pin_ff[NC+NI+1];

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_prev_ff <= 1'b0;
      end else begin
         clk_prev_ff <= p_clk;
      end
   end
   assign clk_rise = p_clk & ~clk_prev_ff;

   // Configuration and programmable memory
   logic                         run_ff;
   logic                         secure_ff;
   logic                         allow_ff;
   logic                         family_ff;
   logic [NC-1:0]                local_ff;
   logic [NC-1:0]                pol_ff;
   logic [pmc_pkg::SIG_BITS-1:0] sig_ff;
   logic [pmc_pkg::DATA_W-1:0]   fuse_ff [pmc_pkg::NUM_TERMS];
   logic [NC-1:0]                q_ff;

   // APB decode
   logic        setup;
   logic        wr_fire;
   logic        is_array;
   logic [5:0]  arr_idx;
   logic        prog_ok;
   logic        erase_req;
   logic [pmc_pkg::DATA_W-1:0] rd_data;
   logic        rd_err;

   assign setup     = psel & ~penable;
   assign wr_fire   = psel & penable & pready & pwrite;
   assign is_array  = (paddr & pmc_pkg::ARRAY_MASK) == pmc_pkg::ARRAY_OFS;
   assign arr_idx   = paddr[7:2];
   assign prog_ok   = ~run_ff & ~secure_ff;
   assign erase_req = wr_fire & ~run_ff & pwdata[0]
                      & (paddr == pmc_pkg::ERASE_OFS);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= 1'b0;
      end else if (wr_fire && paddr == pmc_pkg::RUN_OFS) begin
         run_ff <= pwdata[0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         secure_ff <= 1'b0;
      end else if (erase_req) begin
         secure_ff <= 1'b0;
      end else if (wr_fire && paddr == pmc_pkg::SECURE_OFS && pwdata[0]) begin
         secure_ff <= 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         allow_ff  <= 1'b0;
         family_ff <= 1'b0;
         local_ff  <= '0;
         pol_ff    <= '0;
      end else if (erase_req) begin
         allow_ff  <= 1'b0;
         family_ff <= 1'b0;
         local_ff  <= '0;
         pol_ff    <= '0;
      end else if (wr_fire && prog_ok && paddr == pmc_pkg::CTRL_OFS) begin
         allow_ff  <= pwdata[pmc_pkg::CTRL_ALLOW_POS];
         family_ff <= pwdata[pmc_pkg::CTRL_FAMILY_POS];
         local_ff  <= pwdata[pmc_pkg::CTRL_LOCAL_POS +: NC];
         pol_ff    <= pwdata[pmc_pkg::CTRL_POL_POS +: NC];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sig_ff <= pmc_pkg::SIG_RESET;
      end else if (erase_req) begin
         sig_ff <= pmc_pkg::SIG_RESET;
      end else if (wr_fire && !run_ff && paddr == pmc_pkg::SIG_LO_OFS) begin
         sig_ff[31:0] <= pwdata;
      end else if (wr_fire && !run_ff && paddr == pmc_pkg::SIG_HI_OFS) begin
         sig_ff[63:32] <= pwdata;
      end
   end

   // Array words only program while stopped and unsecured
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int w = 0; w < pmc_pkg::NUM_TERMS; w++) begin
            fuse_ff[w] <= pmc_pkg::FUSE_RESET;
         end
      end else if (erase_req) begin
         for (int w = 0; w < pmc_pkg::NUM_TERMS; w++) begin
            fuse_ff[w] <= pmc_pkg::FUSE_RESET;
         end
      end else if (wr_fire && prog_ok && is_array) begin
         fuse_ff[arr_idx] <= pwdata;
      end
   end

   // Array inputs: dedicated pins then per-cell feedback
   logic [pmc_pkg::NUM_SIGS-1:0] sig;
   logic [pmc_pkg::NUM_SIGS-1:0] sig_vld;
   logic [pmc_pkg::NUM_COLS-1:0] col;
   logic [pmc_pkg::NUM_TERMS-1:0] pt;
   logic [NC-1:0]  fb;
   logic [NC-1:0]  fb_vld;
   logic [NC-1:0]  nxt_out;
   logic [NC-1:0]  nxt_oe;
   logic [NC-1:0]  nxt_q;
   logic [NC-1:0]  is_reg;
   logic [NC-1:0]  unsup;

   assign sig     = {fb, p_in};
   assign sig_vld = {fb_vld, {NI{1'b1}}};

   genvar k;
   genvar c;
   genvar t;
   generate
      // absent signal leaves both columns HIGH
      for (k = 0; k < pmc_pkg::NUM_SIGS; k++) begin : g_col
         assign col[2*k]   = sig_vld[k] ? sig[k]  : 1'b1;
         assign col[2*k+1] = sig_vld[k] ? ~sig[k] : 1'b1;
      end

      for (c = 0; c < NC; c++) begin : g_cell
         localparam int ADJ = (c < NC/2) ? c + 1 : c - 1;
         localparam bit END = (c == 0) || (c == NC - 1);
         localparam bit NOFB = (c == 3) || (c == 4);
         pmc_pkg::pmc_mode_t mode;
         logic fb_sel;
         logic sop;
         logic pol_out;

         for (t = 0; t < pmc_pkg::TERMS_CELL; t++) begin : g_pt
            assign pt[c*8+t] = &(col | ~fuse_ff[c*8+t]);
         end

         always_comb begin
            unique case ({allow_ff, family_ff, local_ff[c]})
               3'b010:  mode = pmc_pkg::PMC_REGISTERED;
               3'b011:  mode = pmc_pkg::PMC_COMB_IO;
               3'b111:  mode = pmc_pkg::PMC_COMB_IO;
               3'b100:  mode = pmc_pkg::PMC_COMB_OUT;
               3'b101:  mode = pmc_pkg::PMC_INPUT;
               default: mode = pmc_pkg::PMC_UNSUPPORTED;
            endcase
         end

         assign fb_sel = END ? ~allow_ff : family_ff;

         always_comb begin
            fb[c]     = 1'b0;
            fb_vld[c] = 1'b1;
            if (mode == pmc_pkg::PMC_UNSUPPORTED) begin
               fb_vld[c] = 1'b0;
            end else if (fb_sel) begin
               fb[c] = local_ff[c] ? p_io[c] : ~q_ff[c];
            end else if (END) begin
               // clock and enable pins as inputs
               fb[c] = (c == 0) ? p_oe_n : p_clk;
            end else if (NOFB && !local_ff[c]) begin
               fb_vld[c] = 1'b0;
            end else begin
               fb[c] = p_io[ADJ];
            end
         end

         assign sop = (family_ff && local_ff[c])
                      ? |pt[c*8 +: 7] : |pt[c*8 +: 8];
         assign pol_out = pol_ff[c] ? sop : ~sop;

         assign is_reg[c] = (mode == pmc_pkg::PMC_REGISTERED);
         assign unsup[c]  = (mode == pmc_pkg::PMC_UNSUPPORTED);
         assign nxt_out[c] = is_reg[c] ? ~q_ff[c] : pol_out;
         // capture inverted so pin follows polarity
         assign nxt_q[c] = ~pol_out;

         always_comb begin
            unique case (mode)
               pmc_pkg::PMC_REGISTERED: nxt_oe[c] = ~p_oe_n;
               pmc_pkg::PMC_COMB_IO:    nxt_oe[c] = pt[c*8+7];
               pmc_pkg::PMC_COMB_OUT:   nxt_oe[c] = 1'b1;
               pmc_pkg::PMC_INPUT:      nxt_oe[c] = 1'b0;
               default:                 nxt_oe[c] = 1'b0;
            endcase
         end
      end
   endgenerate

   // capture on clock pin rising edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         q_ff <= pmc_pkg::Q_RESET;
      end else if (wr_fire && paddr == pmc_pkg::PRELOAD_OFS && pwdata[0]) begin
         q_ff <= ~p_io;
      end else if (run_ff && clk_rise) begin
         q_ff <= (q_ff & ~is_reg) | (nxt_q & is_reg);
      end
   end

   // Pins follow the array one pclk late; buffers stay off until run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         io_out <= '0;
         io_oe  <= '0;
      end else begin
         io_out <= nxt_out;
         io_oe  <= run_ff ? nxt_oe : '0;
      end
   end

   // Register read mux
   always_comb begin
      rd_data = pmc_pkg::WORD_ZERO;
      rd_err  = 1'b0;
      if (is_array) begin
         rd_data = secure_ff ? pmc_pkg::WORD_ZERO : fuse_ff[arr_idx];
      end else begin
         unique case (paddr)
            pmc_pkg::CTRL_OFS: begin
               if (!secure_ff) begin
                  rd_data[pmc_pkg::CTRL_ALLOW_POS]     = allow_ff;
                  rd_data[pmc_pkg::CTRL_FAMILY_POS]    = family_ff;
                  rd_data[pmc_pkg::CTRL_LOCAL_POS +: NC] = local_ff;
                  rd_data[pmc_pkg::CTRL_POL_POS +: NC]   = pol_ff;
               end
            end
            pmc_pkg::RUN_OFS:     rd_data[0] = run_ff;
            pmc_pkg::SIG_LO_OFS:  rd_data = sig_ff[31:0];
            pmc_pkg::SIG_HI_OFS:  rd_data = sig_ff[63:32];
            pmc_pkg::SECURE_OFS:  rd_data[0] = secure_ff;
            pmc_pkg::ERASE_OFS:   rd_data = pmc_pkg::WORD_ZERO;
            pmc_pkg::PRELOAD_OFS: rd_data = pmc_pkg::WORD_ZERO;
            pmc_pkg::STATUS_OFS: begin
               rd_data[pmc_pkg::ST_RUN_POS]    = run_ff;
               rd_data[pmc_pkg::ST_SECURE_POS] = secure_ff;
               rd_data[pmc_pkg::ST_UNSUP_POS]  = |unsup;
               rd_data[pmc_pkg::ST_Q_POS +: NC]   = q_ff;
               rd_data[pmc_pkg::ST_OE_POS +: NC]  = io_oe;
               rd_data[pmc_pkg::ST_OUT_POS +: NC] = io_out;
            end
            default: rd_err = 1'b1;
         endcase
      end
   end

   // Answer in the first access cycle: data latched during setup
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         prdata  <= pmc_pkg::WORD_ZERO;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         if (setup) begin
            prdata  <= pwrite ? pmc_pkg::WORD_ZERO : rd_data;
            pslverr <= rd_err;
         end else if (!psel) begin
            pslverr <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

/* test/pmc_board.sv */
// Board model: resolves the shared I/O pins between device and board
`default_nettype none
module pmc_board (
   input  wire logic [7:0] io_out,
   input  wire logic [7:0] io_oe,
   input  wire logic [7:0] drv_val,
   input  wire logic [7:0] drv_en,
   output var  logic [7:0] io_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // Released pins float up on pull-ups, they never keep old data
   always_comb begin
      for (int i = 0; i < 8; i++) begin
         if (io_oe[i])
            io_in[i] = io_out[i];
         else if (drv_en[i])
            io_in[i] = drv_val[i];
         else
            io_in[i] = 1'b1;
      end
   end
endmodule
`default_nettype wire

/* test/pmc_macrocell_top_chk.sv */
// Checker: bus handshake and output enable properties of the macrocells
`default_nettype none
module pmc_macrocell_top_chk (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [7:0]  in_pin,
   input wire logic        clk_pin,
   input wire logic        oe_n_pin,
   input wire logic [7:0]  io_in,
   input wire logic [7:0]  io_out,
   input wire logic [7:0]  io_oe
);
   timeunit 1ns;
   timeprecision 1ps;
   logic       run_ff;
   logic       sec_ff;
   logic [1:0] mode_ff;
   logic [7:0] loc_ff;
   logic       wr;
   logic       setup;
   assign wr = psel && penable && pready && pwrite;
   assign setup = psel && !penable;
   // Shadow follows accepted writes only; refused ones give no error
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_ff <= 1'b0;
         sec_ff <= 1'b0;
         mode_ff <= 2'b00;
         loc_ff <= 8'h00;
      end else if (wr) begin
         if (paddr == 12'h004)
            run_ff <= pwdata[0];
         if (paddr == 12'h010 && pwdata[0])
            sec_ff <= 1'b1;
         if (paddr == 12'h014 && pwdata[0] && !run_ff) begin
            sec_ff <= 1'b0;
            mode_ff <= 2'b00;
            loc_ff <= 8'h00;
         end
         if (paddr == 12'h000 && !run_ff && !sec_ff) begin
            mode_ff <= pwdata[1:0];
            loc_ff <= pwdata[15:8];
         end
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_ready_answer: assert property (setup |=> pready)
      else $error("no pready after setup");
   a_unmapped_err: assert property (setup && paddr inside {[12'h020:12'h0FC]}
      |=> pslverr && pready && prdata == 32'h0000_0000)
      else $error("unmapped access not refused");
   a_reset_quiet:
   assert property (disable iff (1'b0) !presetn |->
      io_oe == 8'h00 && io_out == 8'h00 && !pready)
      else $error("outputs active in reset");
   a_input_off:
   assert property (mode_ff == 2'b01 |-> (io_oe & loc_ff) == 8'h00)
      else $error("input cell drives its pin");
   a_comb_out_on:
   assert property (run_ff && $past(run_ff) && mode_ff == 2'b01
      |-> (io_oe | loc_ff) == 8'hFF)
      else $error("output cell not enabled");
   a_unsup_off:
   assert property (mode_ff == 2'b00 |-> io_oe == 8'h00)
      else $error("unsupported cell drives");
   a_oe_idle: assert property (!run_ff && !$past(run_ff) |-> io_oe == 8'h00)
      else $error("pin driven while stopped");
   a_secure_hide:
   assert property (setup && !pwrite && sec_ff &&
      (paddr == 12'h000 || paddr[11:8] == 4'h1) |=> prdata == 32'h0000_0000)
      else $error("pattern read while secure");
   c_run: cover property (wr && paddr == 12'h004 && pwdata[0]);
   c_err: cover property (pready && pslverr);
   c_sec_rd: cover property (sec_ff && pready && !pwrite);
endmodule
bind pmc_macrocell_top pmc_macrocell_top_chk u_chk (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .in_pin(in_pin),
   .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_in(io_in),
   .io_out(io_out), .io_oe(io_oe));
`default_nettype wire

/* test/pmc_macrocell_top_tb.sv */
// Testbench: bus set-up of the registered, I/O, output and input cell modes, pin stimulus and checks
`default_nettype none
module pmc_macrocell_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [31:0] ONE = 32'h0000_0001;
   localparam logic [31:0] NIL = 32'h0000_0000;
   logic        pclk = 1'b0;
   logic        presetn = 1'b1;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = NIL;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic [7:0]  in_pin = 8'h00;
   logic        clk_pin = 1'b0;
   logic        oe_n_pin = 1'b1;
   logic [7:0]  io_in;
   logic [7:0]  io_out;
   logic [7:0]  io_oe;
   logic [7:0]  drv_val = 8'h00;
   logic [7:0]  drv_en = 8'h00;
   logic [31:0] rdat;
   logic        rerr;
   int          num_errors = 0;
   int          n_compared = 0;
   // Input pins beside expected pins, polarity F0
   logic [15:0] rows [4] = '{16'h000F, 16'h5A55, 16'hFFF0, 16'h818E};

   always #20 pclk = ~pclk;

   pmc_macrocell_top uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .in_pin(in_pin),
      .clk_pin(clk_pin), .oe_n_pin(oe_n_pin), .io_in(io_in),
      .io_out(io_out), .io_oe(io_oe));
   pmc_board board (
      .io_out(io_out), .io_oe(io_oe), .drv_val(drv_val), .drv_en(drv_en),
      .io_in(io_in));

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic close_out();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   task automatic bus(input logic w, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      if (pready !== 1'b1) begin
         num_errors++;
         close_out();
      end else begin
         rdat = prdata;
         rerr = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic rc(input logic [11:0] a, input logic [31:0] e);
      bus(1'b0, a, NIL);
      chk(rdat, e);
   endtask

   // Pins pass three sync flops and a filter before the logic sees them
   task automatic settle();
      repeat (8) @(posedge pclk);
   endtask

   // Every cell: term 0 is its own input pin, the rest are held false
   task automatic prog();
      bus(1'b1, 12'h014, ONE);
      for (int n = 0; n < 64; n++)
         bus(1'b1, 12'h100 + 12'(4 * n),
             (n % 8 == 0) ? ONE << (n / 4) : 32'h0000_0003);
   endtask

   initial begin
      // Real falling edge at time zero, so flops leave unknown before a clock
      presetn <= 1'b0;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      rc(12'h018, 32'h0000_0004);
      bus(1'b0, 12'h020, NIL);
      chk(rdat, NIL);
      chk(32'(rerr), ONE);
      bus(1'b1, 12'h008, 32'hA5A5_0F0F);
      bus(1'b1, 12'h00C, 32'h1234_5678);
      rc(12'h008, 32'hA5A5_0F0F);
      rc(12'h00C, 32'h1234_5678);
      $display("reset and signature done");
      prog();
      bus(1'b1, 12'h000, 32'h00F0_0001);
      bus(1'b1, 12'h004, ONE);
      foreach (rows[i]) begin
         in_pin <= rows[i][15:8];
         settle();
         chk(32'(io_out), 32'(rows[i][7:0]));
         chk(32'(io_oe), 32'h0000_00FF);
      end
      bus(1'b1, 12'h004, NIL);
      bus(1'b1, 12'h100, 32'h0040_0000);
      bus(1'b1, 12'h004, ONE);
      for (int v = 0; v < 2; v++) begin
         in_pin <= v[0] ? 8'h10 : 8'h00;
         settle();
         chk(32'(io_out[0]), NIL);
      end
      $display("combinatorial output done");
      bus(1'b1, 12'h004, NIL);
      bus(1'b1, 12'h000, 32'h00F0_0F01);
      bus(1'b1, 12'h180, 32'h0010_0000);
      bus(1'b1, 12'h1A0, 32'h4000_0000);
      bus(1'b1, 12'h1C0, 32'h0001_0000);
      bus(1'b1, 12'h004, ONE);
      drv_en <= 8'h08;
      for (int v = 0; v < 2; v++) begin
         clk_pin <= v[0];
         oe_n_pin <= !v[0];
         drv_val <= v[0] ? 8'h08 : 8'h00;
         settle();
         chk(32'(io_out[6:4]), 32'(4 - v));
         chk(32'(io_oe), 32'h0000_00F0);
      end
      bus(1'b1, 12'h004, NIL);
      bus(1'b1, 12'h000, 32'h00FF_FF03);
      bus(1'b1, 12'h120, 32'h0000_0003);
      bus(1'b1, 12'h13C, NIL);
      bus(1'b1, 12'h160, 32'h0010_0000);
      bus(1'b1, 12'h004, ONE);
      drv_en <= 8'h04;
      for (int v = 0; v < 2; v++) begin
         drv_val <= v[0] ? 8'h04 : 8'h00;
         settle();
         chk(32'(io_out[3:1]), 32'(v * 4));
         chk(32'(io_oe), 32'h0000_0002);
      end
      bus(1'b1, 12'h000, NIL);
      rc(12'h000, 32'h00FF_FF03);
      $display("input and i/o modes done");
      presetn <= 1'b0;
      clk_pin <= 1'b0;
      drv_en <= 8'h00;
      repeat (3) @(posedge pclk);
      presetn <= 1'b1;
      prog();
      bus(1'b1, 12'h000, 32'h00FF_0402);
      // Cell 2 is I/O in the registered device; its enable term is empty
      bus(1'b1, 12'h15C, NIL);
      oe_n_pin <= 1'b0;
      in_pin <= 8'h3C;
      bus(1'b1, 12'h004, ONE);
      settle();
      chk(32'(io_out), 32'h0000_00FF);
      chk(32'(io_oe), 32'h0000_00FF);
      clk_pin <= 1'b1;
      settle();
      chk(32'(io_out), 32'h0000_003C);
      oe_n_pin <= 1'b1;
      drv_en <= 8'hFF;
      drv_val <= 8'hA5;
      settle();
      chk(32'(io_oe), 32'h0000_0004);
      bus(1'b1, 12'h01C, ONE);
      settle();
      chk(32'(io_out), 32'h0000_00A5);
      $display("registered mode done");
      bus(1'b1, 12'h004, NIL);
      bus(1'b1, 12'h008, 32'hC3C3_1001);
      bus(1'b1, 12'h010, ONE);
      rc(12'h000, NIL);
      rc(12'h104, NIL);
      rc(12'h008, 32'hC3C3_1001);
      bus(1'b1, 12'h010, NIL);
      rc(12'h010, ONE);
      bus(1'b1, 12'h014, ONE);
      rc(12'h010, NIL);
      $display("security done");
      close_out();
   end
endmodule
`default_nettype wire
